// file: oag_pkg.sv
// Constants and types for the operand address generator
// Overview of operation
// - Immediate operands come from instruction bytes, one byte or one word, no address.
// - Pointer mode picks one of 64 pointers by index, uses its 16 bits unchanged.
// - Pointer low byte at lower RAM address, high byte at next address.
// - Pointer plus C mode adds sign-extended C register to the pointer.
// - Offset mode adds a 7-bit signed displacement to pointer zero.
// - Base classified as RAM, SFR or reserved; SFR and reserved displaced addresses never change area.
// - RAM base with sum leaving RAM area: read returns all ones.
// - SFR base: low eight bits of the sum added to the SFR base.
// - Confinement applies to both offset and C-displaced addresses.
// - Direct mode takes address from operand; short and long encodings both accepted.
// - Table read word fetches two ROM bytes using pointer, pointer+C or offset.
// - Table reads treat pointers as 17-bit values over 128K bytes.
// - ROM bank flag in status word selects the 128K ROM bank for table reads.
// - Table read: main working reg gets byte at address, B the next byte.
// - External access address is B as top byte plus 16-bit computed low part.
// - 64 pointers occupy lowest RAM, two bytes each, up to 7EH.
// - Bank flag clear selects lower 128K, set selects upper 128K.
package oag_pkg;
    localparam logic [15:0] OAG_RAM_TOP = 16'hFDFF;
    localparam logic [15:0] OAG_SFR_BASE = 16'hFE00;
    localparam logic [15:0] OAG_RSV_BASE = 16'hFF00;
    localparam logic [7:0] OAG_ALL_ONES = 8'hFF;
    localparam logic [6:0] OAG_PTR_TOP = 7'h7E;
    localparam int OAG_PTR_COUNT = 64;
    localparam int OAG_BANK_BIT = 3;
    localparam logic [7:0] OAG_FLAGS_RESET = 8'h00;

    typedef enum logic [2:0] {
        OAG_M_IMM8 = 3'b000,
        OAG_M_IMM16 = 3'b001,
        OAG_M_PTR = 3'b010,
        OAG_M_PTRC = 3'b011,
        OAG_M_OFF = 3'b100,
        OAG_M_DIR_S = 3'b101,
        OAG_M_DIR_L = 3'b110
    } oag_mode_e;

    typedef enum logic [1:0] {
        OAG_OP_DATA = 2'b00,
        OAG_OP_TABLE = 2'b01,
        OAG_OP_EXT = 2'b10
    } oag_op_e;

    typedef enum logic [1:0] {
        OAG_A_RAM = 2'b00,
        OAG_A_SFR = 2'b01,
        OAG_A_RSV = 2'b10
    } oag_area_e;

    typedef enum logic [1:0] {
        OAG_S_IDLE = 2'b00,
        OAG_S_PLO = 2'b01,
        OAG_S_PHI = 2'b10,
        OAG_S_ROM2 = 2'b11
    } oag_state_e;
endpackage

// file: oag_confine.sv
// Area confinement of a displaced operand address
`timescale 1ns/1ps
`default_nettype none
module oag_confine
    import oag_pkg::*;
(
    input wire logic [15:0] base,
    input wire logic [7:0] disp,
    output logic [15:0] addr,
    output logic force_ones
);
    wire [15:0] disp_ext = {{8{disp[7]}}, disp};
    wire [15:0] sum = base + disp_ext;
    wire base_ram = base <= OAG_RAM_TOP;
    wire base_sfr = (base >= OAG_SFR_BASE) && (base < OAG_RSV_BASE);
    wire sum_ram = sum <= OAG_RAM_TOP;
    // SFR accesses wrap in their 8-bit space
    wire [15:0] sfr_addr = OAG_SFR_BASE + {8'h00, sum[7:0]};
    wire [15:0] rsv_addr = OAG_RSV_BASE + {8'h00, sum[7:0]};
    // Reserved base wraps too, so it can never fall back into SFR space
    assign addr = base_ram ? sum : (base_sfr ? sfr_addr : rsv_addr);
    assign force_ones = base_ram && !sum_ram;
endmodule
`default_nettype wire

// file: oag_top.sv
// Operand address generator: pointer fetch, displacement and ROM/ext forms
`timescale 1ns/1ps
`default_nettype none
module oag_top
    import oag_pkg::*;
(
    input wire logic CLK_SYS,
    input wire logic SRST,
    input wire logic START,
    input wire logic [2:0] MODE,
    input wire logic [1:0] OP,
    input wire logic [5:0] PTR_INDEX,
    input wire logic [6:0] OFFSET,
    input wire logic [15:0] OPERAND,
    input wire logic [7:0] C_REG,
    input wire logic [7:0] B_REG,
    input wire logic [7:0] PROGRAM_FLAGS_WORD,
    input wire logic [8:0] RAM_RDATA,
    input wire logic [7:0] ROM_RDATA,
    output logic [15:0] RAM_ADDR,
    output logic RAM_RD,
    output logic [17:0] ROM_ADDR,
    output logic ROM_RD,
    output logic [15:0] DATA_ADDR,
    output logic [23:0] EXT_ADDR,
    output logic FORCE_ONES,
    output logic [15:0] IMM_DATA,
    output logic [7:0] MAIN_WORKING_REG,
    output logic [7:0] B_OUT,
    output logic DONE,
    output logic BUSY
);
    oag_state_e state_q, state_d;
    logic busy_q;
    oag_op_e op_q;
    logic [7:0] disp_q;
    logic [7:0] ptr_lo_q;
    logic bank_q;
    logic [15:0] ram_addr_q;
    logic ram_rd_q;
    logic [17:0] rom_addr_q;
    logic rom_rd_q;
    logic [15:0] data_addr_q;
    logic [23:0] ext_addr_q;
    logic force_q;
    logic [15:0] imm_q;
    logic [7:0] acc_q;
    logic [7:0] b_q;
    logic done_q;

    wire [2:0] mode_in = MODE;
    wire is_imm = (mode_in == OAG_M_IMM8) || (mode_in == OAG_M_IMM16);
    // both direct encodings give the same address
    wire is_dir = (mode_in == OAG_M_DIR_S) || (mode_in == OAG_M_DIR_L);
    wire is_ind = (mode_in == OAG_M_PTR) || (mode_in == OAG_M_PTRC) ||
        (mode_in == OAG_M_OFF);
    // Unused code 3'b111 is dropped without DONE rather than guessed at
    wire is_single = is_imm || is_dir;
    // offset mode always uses pointer zero
    wire [5:0] ptr_sel = (mode_in == OAG_M_OFF) ? 6'h00 : PTR_INDEX;
    // pointer n sits at byte 2n, the last one at 7EH
    wire [15:0] ptr_lo_addr = {9'h000, ptr_sel, 1'b0};
    wire [15:0] ptr_hi_addr = ptr_lo_addr + 16'h0001;
    wire [7:0] disp_in = (mode_in == OAG_M_PTRC) ? C_REG :
        (mode_in == OAG_M_OFF) ? {OFFSET[6], OFFSET} : 8'h00;
    wire [15:0] ptr_val = {RAM_RDATA[7:0], ptr_lo_q};
    wire [15:0] conf_addr;
    wire conf_ones;

    // one confinement path for offset and C displacement
    oag_confine u_conf (
        .base(ptr_val),
        .disp(disp_q),
        .addr(conf_addr),
        .force_ones(conf_ones)
    );

    // ROM table address: 17 bits plus bank bit on top
    wire [16:0] sum17 = {RAM_RDATA[8], ptr_val} +
        {{9{disp_q[7]}}, disp_q};
    wire [17:0] rom_base = {bank_q, sum17};
    wire [17:0] rom_next = {bank_q, sum17 + 17'h00001};
    wire [15:0] low_addr = (disp_q == 8'h00) ? ptr_val : conf_addr;

    always_comb begin
        state_d = state_q;
        unique case (state_q)
            OAG_S_IDLE: if (START && is_ind) state_d = OAG_S_PLO;
            OAG_S_PLO: state_d = OAG_S_PHI;
            OAG_S_PHI: state_d = (op_q == OAG_OP_TABLE) ?
                OAG_S_ROM2 : OAG_S_IDLE;
            OAG_S_ROM2: state_d = OAG_S_IDLE;
        endcase
    end

    always_ff @(posedge CLK_SYS) begin
        if (SRST) begin
            state_q <= OAG_S_IDLE;
            busy_q <= 1'b0;
        end else begin
            state_q <= state_d;
            // Registered so BUSY leaves the block straight from a flop
            busy_q <= state_d != OAG_S_IDLE;
        end
    end

    // Request capture
    always_ff @(posedge CLK_SYS) begin
        if (SRST) begin
            op_q <= OAG_OP_DATA;
            disp_q <= 8'h00;
            bank_q <= 1'b0;
        end else if (START && state_q == OAG_S_IDLE) begin
            op_q <= oag_op_e'(OP);
            disp_q <= disp_in;
            bank_q <= PROGRAM_FLAGS_WORD[OAG_BANK_BIT];
        end
    end

    // Pointer fetch over two RAM reads, low byte first
    always_ff @(posedge CLK_SYS) begin
        if (SRST) begin
            ram_addr_q <= 16'h0000;
            ram_rd_q <= 1'b0;
            ptr_lo_q <= 8'h00;
        end else begin
            ram_rd_q <= 1'b0;
            if (START && state_q == OAG_S_IDLE && is_ind) begin
                ram_addr_q <= ptr_lo_addr;
                ram_rd_q <= 1'b1;
            end else if (state_q == OAG_S_PLO) begin
                ram_addr_q <= ptr_hi_addr;
                ram_rd_q <= 1'b1;
                ptr_lo_q <= RAM_RDATA[7:0];
            end
        end
    end

    // Final addresses and immediate data
    always_ff @(posedge CLK_SYS) begin
        if (SRST) begin
            data_addr_q <= 16'h0000;
            ext_addr_q <= 24'h000000;
            force_q <= 1'b0;
            imm_q <= 16'h0000;
            done_q <= 1'b0;
        end else begin
            done_q <= 1'b0;
            if (START && state_q == OAG_S_IDLE && is_single) begin
                done_q <= 1'b1;
                force_q <= 1'b0;
                if (mode_in == OAG_M_IMM8)
                    imm_q <= {8'h00, OPERAND[7:0]};
                else if (mode_in == OAG_M_IMM16)
                    imm_q <= OPERAND;
                else
                    data_addr_q <= OPERAND;
            end else if (state_q == OAG_S_PHI && op_q != OAG_OP_TABLE) begin
                done_q <= 1'b1;
                data_addr_q <= low_addr;
                // Masking only makes sense for internal reads
                force_q <= (op_q == OAG_OP_DATA) && conf_ones;
                ext_addr_q <= {B_REG, low_addr};
            end else if (state_q == OAG_S_ROM2) begin
                done_q <= 1'b1;
                force_q <= 1'b0;
            end
        end
    end

    // Table read word: two ROM reads, base then next byte
    always_ff @(posedge CLK_SYS) begin
        if (SRST) begin
            rom_addr_q <= 18'h00000;
            rom_rd_q <= 1'b0;
            acc_q <= OAG_FLAGS_RESET;
            b_q <= OAG_FLAGS_RESET;
        end else begin
            rom_rd_q <= 1'b0;
            if (state_q == OAG_S_PHI && op_q == OAG_OP_TABLE) begin
                rom_addr_q <= rom_base;
                rom_rd_q <= 1'b1;
            end else if (state_q == OAG_S_ROM2) begin
                acc_q <= ROM_RDATA;
                rom_addr_q <= rom_next;
                rom_rd_q <= 1'b1;
            end else if (rom_rd_q) begin
                b_q <= ROM_RDATA;
            end
        end
    end

    assign RAM_ADDR = ram_addr_q;
    assign RAM_RD = ram_rd_q;
    assign ROM_ADDR = rom_addr_q;
    assign ROM_RD = rom_rd_q;
    assign DATA_ADDR = data_addr_q;
    assign EXT_ADDR = ext_addr_q;
    assign FORCE_ONES = force_q;
    assign IMM_DATA = imm_q;
    assign MAIN_WORKING_REG = acc_q;
    assign B_OUT = b_q;
    assign DONE = done_q;
    assign BUSY = busy_q;

    // Checks
    a_ptr_hi_follows: assert property (@(posedge CLK_SYS) disable iff (SRST)
        state_q == OAG_S_PLO |=> RAM_RD && RAM_ADDR == $past(RAM_ADDR) + 16'h1)
        else $error("pointer high byte not read next");
    a_ptr_index: assert property (@(posedge CLK_SYS) disable iff (SRST)
        START && !BUSY && MODE == 3'b010 |=>
        RAM_ADDR == {9'h000, $past(PTR_INDEX), 1'b0})
        else $error("pointer index address wrong");
    a_off_uses_r0: assert property (@(posedge CLK_SYS) disable iff (SRST)
        START && !BUSY && MODE == 3'b100 |=> RAM_ADDR == 16'h0000)
        else $error("offset mode not on pointer zero");
    a_direct_addr: assert property (@(posedge CLK_SYS) disable iff (SRST)
        START && !BUSY && (MODE == 3'b101 || MODE == 3'b110) |=>
        DONE && DATA_ADDR == $past(OPERAND))
        else $error("direct address wrong");
    a_imm_no_fetch: assert property (@(posedge CLK_SYS) disable iff (SRST)
        START && !BUSY && MODE == 3'b001 |=>
        DONE && !RAM_RD && IMM_DATA == $past(OPERAND))
        else $error("immediate word wrong");
    a_sfr_wrap: assert property (@(posedge CLK_SYS) disable iff (SRST)
        DONE && BUSY == 1'b0 && $past(state_q) == OAG_S_PHI &&
        $past(ptr_val) >= 16'hFE00 && $past(ptr_val) < 16'hFF00 |->
        DATA_ADDR[15:8] == 8'hFE)
        else $error("SFR access escaped its area");
    a_ram_ones: assert property (@(posedge CLK_SYS) disable iff (SRST)
        FORCE_ONES |-> DATA_ADDR > 16'hFDFF)
        else $error("all-ones flag without leaving RAM");
    a_ext_top: assert property (@(posedge CLK_SYS) disable iff (SRST)
        DONE && $past(state_q) == OAG_S_PHI && $past(op_q) == OAG_OP_EXT |->
        EXT_ADDR[23:8] == {$past(B_REG), DATA_ADDR[15:8]})
        else $error("external top byte wrong");
    a_rom_pair: assert property (@(posedge CLK_SYS) disable iff (SRST)
        state_q == OAG_S_ROM2 |=> ROM_RD && ROM_ADDR[16:0] ==
        $past(ROM_ADDR[16:0]) + 17'h1 && ROM_ADDR[17] == $past(ROM_ADDR[17]))
        else $error("second table byte address wrong");
    a_ind_busy: assert property (@(posedge CLK_SYS) disable iff (SRST)
        START && !BUSY && is_ind |=> BUSY && RAM_RD)
        else $error("pointer fetch not started");
    a_imm_byte: assert property (@(posedge CLK_SYS) disable iff (SRST)
        START && !BUSY && MODE == 3'b000 |=>
        DONE && !RAM_RD && IMM_DATA[7:0] == $past(OPERAND[7:0]))
        else $error("immediate byte wrong");
    a_ram_sum: assert property (@(posedge CLK_SYS) disable iff (SRST)
        DONE && !BUSY && $past(state_q) == OAG_S_PHI &&
        $past(ptr_val) <= 16'hFDFF |->
        DATA_ADDR == $past(ptr_val) + {{8{$past(disp_q[7])}}, $past(disp_q)})
        else $error("displaced RAM address wrong");
    a_sfr_low: assert property (@(posedge CLK_SYS) disable iff (SRST)
        DONE && !BUSY && $past(state_q) == OAG_S_PHI &&
        $past(ptr_val) >= 16'hFE00 && $past(ptr_val) < 16'hFF00 |->
        DATA_ADDR[7:0] == $past(ptr_val[7:0]) + $past(disp_q))
        else $error("SFR low byte wrong");
    a_rsv_wrap: assert property (@(posedge CLK_SYS) disable iff (SRST)
        DONE && !BUSY && $past(state_q) == OAG_S_PHI &&
        $past(ptr_val) >= 16'hFF00 |-> DATA_ADDR[15:8] == 8'hFF)
        else $error("reserved access escaped its area");
    a_ext_low: assert property (@(posedge CLK_SYS) disable iff (SRST)
        DONE && $past(state_q) == OAG_S_PHI && $past(op_q) == OAG_OP_EXT |->
        EXT_ADDR[15:0] == DATA_ADDR)
        else $error("external low word wrong");
    a_tbl_bank: assert property (@(posedge CLK_SYS) disable iff (SRST)
        START && !BUSY && is_ind && OP == 2'b01 |-> ##3 ROM_RD &&
        ROM_ADDR[17] == $past(PROGRAM_FLAGS_WORD[OAG_BANK_BIT], 3))
        else $error("table bank bit wrong");
    a_tbl_bit16: assert property (@(posedge CLK_SYS) disable iff (SRST)
        state_q == OAG_S_PHI && op_q == OAG_OP_TABLE && disp_q == 8'h00 |=>
        ROM_RD && ROM_ADDR[16:0] == {$past(RAM_RDATA[8]), $past(ptr_val)})
        else $error("table address not 17-bit pointer");
    a_tbl_acc: assert property (@(posedge CLK_SYS) disable iff (SRST)
        state_q == OAG_S_ROM2 |=> DONE && MAIN_WORKING_REG == $past(ROM_RDATA))
        else $error("table low byte not loaded");
    a_tbl_b: assert property (@(posedge CLK_SYS) disable iff (SRST)
        state_q == OAG_S_ROM2 |-> ##2 B_OUT == $past(ROM_RDATA))
        else $error("table high byte not loaded");

    c_table: cover property (@(posedge CLK_SYS) state_q == OAG_S_ROM2);
    c_ptr_data: cover property (@(posedge CLK_SYS)
        DONE && op_q == OAG_OP_DATA && !FORCE_ONES);
    c_bank_hi: cover property (@(posedge CLK_SYS) ROM_RD && ROM_ADDR[17]);
    c_ones: cover property (@(posedge CLK_SYS) FORCE_ONES);
    c_ext: cover property (@(posedge CLK_SYS) DONE && op_q == OAG_OP_EXT);
endmodule
`default_nettype wire

// file: oag_mem_model.sv
// Behavioural RAM and program ROM facing the address generator
`timescale 1ns/1ps
`default_nettype none
module oag_mem_model (
    input wire logic [15:0] ram_addr,
    input wire logic [17:0] rom_addr,
    output logic [8:0] ram_rdata,
    output logic [7:0] rom_rdata
);
    logic [8:0] ram_q [0:127];
    // Low ninth bit is the inverse of the high one to expose a wrong pick
    task automatic set_ptr(input logic [5:0] n, input logic [16:0] v);
        ram_q[{n, 1'b0}] = {~v[16], v[7:0]};
        ram_q[{n, 1'b1}] = {v[16], v[15:8]};
    endtask
    // Data outside the pointers follows the address, so stale reads show
    assign ram_rdata = (ram_addr < 16'h0080) ?
        ram_q[ram_addr[6:0]] : {1'b1, ~ram_addr[7:0]};
    assign rom_rdata = rom_addr[7:0] ^ rom_addr[15:8] ^
        {rom_addr[17:16], 6'h15};
endmodule
`default_nettype wire

// file: test_oag_top.sv
// Self-checking bench for the operand address generator
`timescale 1ns/1ps
`default_nettype none
module test_oag_top;
    import oag_pkg::*;
    logic clk_sys = 1'b0;
    logic srst = 1'b1;
    logic start = 1'b0;
    logic [2:0] mode = 3'h0;
    logic [1:0] op = 2'h0;
    logic [5:0] idx = 6'h00;
    logic [6:0] off = 7'h00;
    logic [15:0] opd = 16'h0000;
    logic [7:0] c_reg = 8'h00;
    logic [7:0] b_reg = 8'h00;
    logic [7:0] flags = 8'h00;
    logic [8:0] ram_rdata;
    logic [7:0] rom_rdata;
    logic [15:0] ram_addr;
    logic [17:0] rom_addr;
    logic [15:0] data_addr;
    logic [23:0] ext_addr;
    logic [15:0] imm_data;
    logic [7:0] mwr;
    logic [7:0] b_out;
    logic force_ones;
    logic done;
    logic ram_rd;
    logic rom_rd;
    logic busy;
    int n_errors = 0;
    int checks_done = 0;
    int cycles = 0;

    oag_top u_dut (.CLK_SYS(clk_sys), .SRST(srst), .START(start),
        .MODE(mode), .OP(op), .PTR_INDEX(idx), .OFFSET(off),
        .OPERAND(opd), .C_REG(c_reg), .B_REG(b_reg),
        .PROGRAM_FLAGS_WORD(flags), .RAM_RDATA(ram_rdata),
        .ROM_RDATA(rom_rdata), .RAM_ADDR(ram_addr), .RAM_RD(ram_rd),
        .ROM_ADDR(rom_addr), .ROM_RD(rom_rd), .DATA_ADDR(data_addr),
        .EXT_ADDR(ext_addr), .FORCE_ONES(force_ones),
        .IMM_DATA(imm_data), .MAIN_WORKING_REG(mwr), .B_OUT(b_out),
        .DONE(done), .BUSY(busy));
    oag_mem_model u_mem (.ram_addr(ram_addr), .rom_addr(rom_addr),
        .ram_rdata(ram_rdata), .rom_rdata(rom_rdata));

    initial forever #5 clk_sys = ~clk_sys;
    // Whole run needs well under a thousand cycles
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 3000) begin
            n_errors++;
            results();
        end
    end

    task automatic results();
        $display("checks %0d errors %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    task automatic chk(input logic [23:0] got, input logic [23:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    function automatic logic [7:0] romb(input logic [17:0] a);
        return a[7:0] ^ a[15:8] ^ {a[17:16], 6'h15};
    endfunction

    // One request, then a bounded wait for completion
    task automatic issue(input logic [2:0] m, input logic [1:0] o,
        input logic [5:0] i, input logic [6:0] d);
        int n;
        logic ind;
        logic [5:0] pi;
        n = 0;
        ind = (m == OAG_M_PTR) || (m == OAG_M_PTRC) || (m == OAG_M_OFF);
        pi = (m == OAG_M_OFF) ? 6'h00 : i;
        @(negedge clk_sys);
        mode = m;
        op = o;
        idx = i;
        off = d;
        start = 1'b1;
        @(negedge clk_sys);
        start = 1'b0;
        chk(busy, ind);
        chk(ram_rd, ind);
        if (ind) begin
            chk(ram_addr, {9'h000, pi, 1'b0});
            @(negedge clk_sys);
            chk(ram_addr, {9'h000, pi, 1'b1});
        end
        while (done !== 1'b1 && n < 10) begin
            @(negedge clk_sys);
            n++;
        end
        chk(done, 1'b1);
    endtask

    task automatic dsp(input logic [2:0] m, input logic [15:0] base,
        input logic [7:0] d, input logic [15:0] exp, input logic f);
        u_mem.set_ptr(6'h00, {1'b0, base});
        c_reg = d;
        issue(m, OAG_OP_DATA, 6'h00, d[6:0]);
        chk(force_ones, f);
        if (!f)
            chk(data_addr, exp);
    endtask

    task automatic t_imm();
        opd = 16'h1234;
        issue(OAG_M_IMM16, OAG_OP_DATA, 6'h00, 7'h00);
        chk(imm_data, 16'h1234);
        opd = 16'h0012;
        issue(OAG_M_IMM8, OAG_OP_DATA, 6'h00, 7'h00);
        chk(imm_data[7:0], 8'h12);
    endtask

    task automatic t_dir();
        opd = 16'h0123;
        issue(OAG_M_DIR_S, OAG_OP_DATA, 6'h00, 7'h00);
        chk(data_addr, 16'h0123);
        opd = 16'hFE06;
        issue(OAG_M_DIR_L, OAG_OP_DATA, 6'h00, 7'h00);
        chk(data_addr, 16'hFE06);
    endtask

    task automatic t_ptr();
        u_mem.set_ptr(6'h03, 17'h00123);
        issue(OAG_M_PTR, OAG_OP_DATA, 6'h03, 7'h00);
        chk(data_addr, 16'h0123);
        u_mem.set_ptr(6'h3F, 17'h0FE02);
        issue(OAG_M_PTR, OAG_OP_DATA, 6'h3F, 7'h00);
        chk(data_addr, 16'hFE02);
    endtask

    task automatic t_ptrc();
        dsp(OAG_M_PTRC, 16'h0123, 8'h02, 16'h0125, 1'b0);
        dsp(OAG_M_PTRC, 16'hFE02, 8'hFF, 16'hFE01, 1'b0);
        dsp(OAG_M_PTRC, 16'hFDFF, 8'h01, 16'h0000, 1'b1);
        dsp(OAG_M_PTRC, 16'hFEFF, 8'h02, 16'hFE01, 1'b0);
        dsp(OAG_M_PTRC, 16'hFF10, 8'h80, 16'hFF90, 1'b0);
    endtask

    task automatic t_off();
        dsp(OAG_M_OFF, 16'h0123, 8'h10, 16'h0133, 1'b0);
        dsp(OAG_M_OFF, 16'hFE02, 8'h7E, 16'hFE00, 1'b0);
        dsp(OAG_M_OFF, 16'h0100, 8'h3F, 16'h013F, 1'b0);
        dsp(OAG_M_OFF, 16'h0100, 8'h40, 16'h00C0, 1'b0);
        dsp(OAG_M_OFF, 16'hFDFF, 8'h01, 16'h0000, 1'b1);
        dsp(OAG_M_OFF, 16'hFEFF, 8'h02, 16'hFE01, 1'b0);
    endtask

    task automatic t_table();
        u_mem.set_ptr(6'h00, 17'h12340);
        flags = 8'h08;
        issue(OAG_M_OFF, OAG_OP_TABLE, 6'h00, 7'h7F);
        chk(mwr, romb(18'h3233F));
        chk(rom_rd, 1'b1);
        chk(rom_addr, 18'h32340);
        @(negedge clk_sys);
        chk(b_out, romb(18'h32340));
        flags = 8'h00;
        u_mem.set_ptr(6'h03, 17'h08001);
        c_reg = 8'h02;
        issue(OAG_M_PTRC, OAG_OP_TABLE, 6'h03, 7'h00);
        chk(mwr, romb(18'h08003));
        u_mem.set_ptr(6'h05, 17'h10005);
        issue(OAG_M_PTR, OAG_OP_TABLE, 6'h05, 7'h00);
        chk(mwr, romb(18'h10005));
        @(negedge clk_sys);
        chk(b_out, romb(18'h10006));
    endtask

    task automatic t_ext();
        b_reg = 8'h12;
        u_mem.set_ptr(6'h05, 17'h03456);
        issue(OAG_M_PTR, OAG_OP_EXT, 6'h05, 7'h00);
        chk(ext_addr, 24'h123456);
        b_reg = 8'hAB;
        c_reg = 8'hFF;
        issue(OAG_M_PTRC, OAG_OP_EXT, 6'h05, 7'h00);
        chk(ext_addr, 24'hAB3455);
        u_mem.set_ptr(6'h00, 17'h03456);
        issue(OAG_M_OFF, OAG_OP_EXT, 6'h00, 7'h01);
        chk(ext_addr, 24'hAB3457);
    endtask

    initial begin
        repeat (10) @(negedge clk_sys);
        srst = 1'b0;
        t_imm();
        t_dir();
        t_ptr();
        t_ptrc();
        t_off();
        t_table();
        t_ext();
        results();
    end
endmodule
`default_nettype wire
